/* core/rcl_seq.sv */
// Reset, PLL start-up, low-power and protect sequencer with a small PWM.
// Assumes clk_sys is the core clock and all pin inputs are synchronous to it.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rcl_params.svh"
module rcl_seq #(
  parameter int LOCK_REF = `RCL_LOCK_REF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire rcl_pkg::rcl_axi_req_t axi_req,
  output var rcl_pkg::rcl_axi_rsp_t axi_rsp,
  // System reset pin
  input wire logic sys_rst_pin_i,
  output logic sys_rst_pin_o,
  output logic sys_rst_pin_oe,
  // Event sources
  input wire logic wdog_expire,
  input wire logic power_drive_protect_n,
  input wire logic [1:0] external_irq,
  // Test data pin
  input wire logic tdi_i,
  input wire logic trst_i,
  output logic tdi_o,
  output logic tdi_oe,
  // Clock and power state
  output logic core_clock_output,
  output logic core_clk_run,
  output logic cpu_run,
  output logic osc_on,
  output logic pll_locked,
  output logic boot_rom_en,
  output logic vec_fetch,
  output logic [1:0] vec_id,
  // PWM pins
  output logic [`RCL_PWM_N-1:0] pwm_o,
  output logic [`RCL_PWM_N-1:0] pwm_oe
);
  import rcl_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rs1_q;
  logic rs2_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_duty(input logic [7:0] a);
    return a >= `RCL_OFF_DUTY0 && a < 8'(`RCL_OFF_DUTY0 + 4 * `RCL_PWM_N) && a[1:0] == 2'h0;
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  rcl_state_t s_q;
  rcl_state_t s_d;
  logic tick;
  logic [3:0] need;
  logic pdp_hit;
  logic [1:0] xi_edge;
  logic wr;
  logic rd;
  logic [31:0] wv;
  logic [31:0] rv;
  logic [7:0] di;

  always_comb begin
    s_d = s_q;
    s_d.vfetch = 1'b0;
    wr = s_q.axi.awready;
    rd = s_q.axi.arready;
    di = 8'((axi_req.awaddr - `RCL_OFF_DUTY0) >> 2);
    // The reference rate is a quarter of the core clock.
    tick = s_q.refdiv == 2'(`RCL_REF_DIV - 1); // RL9
    s_d.refdiv = tick ? 2'h0 : 2'(s_q.refdiv + 2'h1);

    // Protect input qualification and emergency PWM stop.
    need = s_q.ctl2[`RCL_SC2_QUAL] ? 4'(`RCL_QUAL_LONG) : 4'(`RCL_QUAL_SHORT);
    pdp_hit = !power_drive_protect_n && s_q.pdp_cnt == 4'(need - 4'h1); // RL21
    if (power_drive_protect_n) begin
      s_d.pdp_cnt = 4'h0;
    end else if (s_q.pdp_cnt != need) begin
      s_d.pdp_cnt = 4'(s_q.pdp_cnt + 4'h1);
    end

    // Interrupt edges, pending flags and vector timing.
    xi_edge = external_irq ^ s_q.xi_prev;
    s_d.xi_prev = external_irq;
    if (s_q.vbusy && s_q.vcnt != 4'h0) begin
      s_d.vcnt = 4'(s_q.vcnt - 4'h1);
    end else if (s_q.vbusy && s_q.cpu_run) begin
      s_d.vfetch = 1'b1; // RL17
      s_d.vbusy = 1'b0;
      s_d.pend[s_q.vid] = 1'b0;
    end else if (!s_q.vbusy && s_q.pend != 3'h0) begin
      s_d.vbusy = 1'b1;
      s_d.vid = s_q.pend[0] ? 2'd0 : (s_q.pend[1] ? 2'd1 : 2'd2);
      s_d.vcnt = 4'(`RCL_IRQ_VEC - 2);
    end
    s_d.pend[1:0] = s_d.pend[1:0] | (xi_edge & s_q.irq_en[1:0]);
    s_d.pend[2] = s_d.pend[2] | (pdp_hit & s_q.irq_en[2]); // RL16

    // PWM counter and compare.
    if (s_q.pwm_cnt >= 16'(s_q.period - 16'h1)) begin
      s_d.pwm_cnt = 16'h0;
    end else begin
      s_d.pwm_cnt = 16'(s_q.pwm_cnt + 16'h1);
    end
    for (int i = 0; i < `RCL_PWM_N; i++) begin
      s_d.pwm[i] = s_q.pwm_cnt < s_q.duty[i]; // RL19
    end

    // Sequencer.
    unique case (s_q.st)
      ST_RST: begin
        s_d.rst_oe = 1'b0;
        s_d.osc_on = 1'b1;
        s_d.locked = 1'b0;
        s_d.cpu_run = 1'b0;
        s_d.clk_run = 1'b0;
        s_d.halt_wake = 1'b0;
        s_d.cnt = 16'h0;
        s_d.ctl2[`RCL_SC2_BOOT] = tdi_i; // RL5 RL6
        if (sys_rst_pin_i) begin
          s_d.st = ST_LOCK; // RL1
        end
      end
      ST_LOCK: begin
        if (tick) begin
          s_d.cnt = 16'(s_q.cnt + 16'h1);
          if (s_q.cnt == 16'(LOCK_REF - 1)) begin
            s_d.locked = 1'b1; // RL2 RL15
            s_d.clk_run = 1'b1;
            s_d.cnt = 16'h0;
            s_d.st = s_q.halt_wake ? ST_RUN : ST_VEC;
            s_d.cpu_run = s_q.halt_wake;
            s_d.halt_wake = 1'b0;
          end
        end
      end
      ST_VEC: begin
        s_d.cnt = 16'(s_q.cnt + 16'h1);
        if (s_q.cnt == 16'(`RCL_VEC_CYC - 1)) begin
          s_d.cpu_run = 1'b1; // RL3
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr && axi_req.awaddr == `RCL_OFF_IDLE) begin
          s_d.cpu_run = 1'b0;
          s_d.cnt = 16'h0;
          s_d.st = ST_IDLE;
        end
      end
      ST_WDOG: begin
        if (tick) begin
          s_d.cnt = 16'(s_q.cnt + 16'h1);
          if (s_q.cnt == 16'(`RCL_WDOG_REF - 1)) begin
            s_d.rst_oe = 1'b0; // RL4
            s_d.st = ST_RST;
          end
        end
      end
      ST_IDLE: begin
        s_d.cnt = 16'(s_q.cnt + 16'h1);
        if (s_q.cnt == 16'(`RCL_IDLE_STOP - 1)) begin
          s_d.clk_run = s_q.ctl1[1:0] == 2'd0; // RL11
          if (s_q.ctl1[1] || s_q.ctl1[`RCL_SC1_OSCPD]) begin
            s_d.osc_on = 1'b0; // RL12
            s_d.locked = 1'b0;
          end
          s_d.st = s_q.ctl1[1] ? ST_HALT : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (s_q.pend != 3'h0) begin
          s_d.cnt = 16'h0; // RL13
          s_d.osc_on = 1'b1;
          s_d.halt_wake = 1'b1;
          s_d.clk_run = s_q.locked;
          s_d.st = s_q.locked ? ST_WAKE : ST_LOCK;
        end
      end
      ST_HALT: begin
        if (pdp_hit) begin
          s_d.osc_on = 1'b1; // RL14
          s_d.halt_wake = 1'b1;
          s_d.cnt = 16'h0;
          s_d.st = ST_LOCK;
        end
      end
      ST_WAKE: begin
        s_d.cnt = 16'(s_q.cnt + 16'h1);
        if (s_q.cnt == (s_q.ctl1[0] ? 16'(`RCL_WAKE1 - 1) : 16'(`RCL_WAKE0 - 1))) begin
          s_d.cpu_run = 1'b1; // RL10
          s_d.halt_wake = 1'b0;
          s_d.st = ST_RUN;
        end
      end
    endcase
    if (s_q.st != ST_WDOG && wdog_expire) begin
      // Restart the reference phase so the pulse spans whole reference cycles.
      s_d.refdiv = 2'h0; // RL4
      s_d.rst_oe = 1'b1;
      s_d.cpu_run = 1'b0;
      s_d.cnt = 16'h0;
      s_d.st = ST_WDOG;
    end else if (s_q.st != ST_WDOG && !sys_rst_pin_i) begin
      s_d.st = ST_RST;
    end

    // Shared pin and test pin.
    s_d.clk_pin = s_q.pinsel[`RCL_PIN_CORE_CLOCK_OUTPUT] && (s_d.clk_run ? !s_q.clk_pin : 1'b1); // RL7 RL11
    s_d.tdi_oe = !trst_i && s_q.st inside {ST_RUN, ST_IDLE, ST_SLEEP, ST_HALT, ST_WAKE}; // RL5

    // Register bus: address and data are taken together, one cycle later.
    s_d.axi.awready = axi_req.awvalid && axi_req.wvalid && !s_q.axi.awready && !s_q.axi.bvalid;
    s_d.axi.wready = s_d.axi.awready;
    s_d.axi.arready = axi_req.arvalid && !s_q.axi.arready && !s_q.axi.rvalid;
    if (s_q.axi.bvalid && axi_req.bready) begin
      s_d.axi.bvalid = 1'b0;
    end
    if (s_q.axi.rvalid && axi_req.rready) begin
      s_d.axi.rvalid = 1'b0;
    end
    if (wr) begin
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = 2'h0;
      unique case (axi_req.awaddr)
        `RCL_OFF_SC1: begin
          wv = wmerge({24'h0, s_q.ctl1}, axi_req.wdata, axi_req.wstrb);
          s_d.ctl1 = wv[7:0]; // RL8
        end
        `RCL_OFF_SC2: begin
          wv = wmerge({24'h0, s_q.ctl2}, axi_req.wdata, axi_req.wstrb);
          s_d.ctl2 = wv[7:0];
        end
        `RCL_OFF_PINSEL: begin
          wv = wmerge({24'h0, s_q.pinsel}, axi_req.wdata, axi_req.wstrb);
          s_d.pinsel = wv[7:0];
          s_d.general_output_port_b5 = wv[5];
        end
        `RCL_OFF_IDLE: begin
          wv = 32'h0;
        end
        `RCL_OFF_IRQEN: begin
          wv = wmerge({29'h0, s_q.irq_en}, axi_req.wdata, axi_req.wstrb);
          s_d.irq_en = wv[2:0];
        end
        `RCL_OFF_PWMCTL: begin
          wv = wmerge({15'h0, s_q.pwm_en, s_q.period}, axi_req.wdata, axi_req.wstrb);
          s_d.period = wv[15:0];
          s_d.pwm_en = wv[`RCL_PWM_EN];
        end
        default: begin
          wv = wmerge({16'h0, s_q.duty[di]}, axi_req.wdata, axi_req.wstrb);
          if (is_duty(axi_req.awaddr)) begin
            s_d.duty[di] = wv[15:0];
          end else begin
            s_d.axi.bresp = 2'h2;
          end
        end
      endcase
    end else begin
      wv = 32'h0;
    end
    if (!power_drive_protect_n) begin
      s_d.pwm_en = 1'b0; // RL18
    end
    if (rd) begin
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rresp = 2'h0;
      unique case (axi_req.araddr)
        `RCL_OFF_SC1: rv = {24'h0, s_q.ctl1};
        `RCL_OFF_SC2: rv = {24'h0, s_q.ctl2};
        `RCL_OFF_PINSEL: rv = {24'h0, s_q.pinsel};
        `RCL_OFF_IDLE: rv = 32'h0;
        `RCL_OFF_IRQEN: rv = {26'h0, s_q.pend, s_q.irq_en};
        `RCL_OFF_STAT: rv = {22'h0, s_q.osc_on, s_q.locked, s_q.clk_run, s_q.cpu_run,
                             s_q.rst_oe, !s_q.ctl2[`RCL_SC2_BOOT], 4'(s_q.st)};
        `RCL_OFF_PWMCTL: rv = {15'h0, s_q.pwm_en, s_q.period};
        default: begin
          rv = 32'h0;
          if (is_duty(axi_req.araddr)) begin
            rv = {16'h0, s_q.duty[8'((axi_req.araddr - `RCL_OFF_DUTY0) >> 2)]};
          end else begin
            s_d.axi.rresp = 2'h2;
          end
        end
      endcase
      s_d.axi.rdata = rv;
    end else begin
      rv = 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rs2_q) begin
    if (!rs2_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // The PWM enable gate is the one deliberate combinational path: the protect
  // input must release the pins without waiting for a clock edge.
  assign axi_rsp = s_q.axi; // RL20
  assign sys_rst_pin_o = 1'b0;
  assign sys_rst_pin_oe = s_q.rst_oe; // RL4
  assign tdi_o = s_q.general_output_port_b5;
  assign tdi_oe = s_q.tdi_oe;
  assign core_clock_output = s_q.clk_pin;
  assign core_clk_run = s_q.clk_run;
  assign cpu_run = s_q.cpu_run;
  assign osc_on = s_q.osc_on;
  assign pll_locked = s_q.locked;
  assign boot_rom_en = !s_q.ctl2[`RCL_SC2_BOOT];
  assign vec_fetch = s_q.vfetch;
  assign vec_id = s_q.vid;
  assign pwm_o = s_q.pwm;
  assign pwm_oe = {`RCL_PWM_N{s_q.pwm_en && power_drive_protect_n}}; // RL18
endmodule // rcl_seq
`default_nettype wire

/* core/rcl_params.svh */
// Constants for the reset, clock and low-power sequencer.
// Assumes one core clock; the reference clock is a derived enable pulse.
//
// Overview of operation
// RL1: Board holds reset pin low at least 8 reference cycles with stable clock.
// RL2: After reset pin rises, PLL locks within 4096 reference cycles.
// RL3: Reset vector runs no sooner than 36 core half-periods after lock.
// RL4: Watchdog reset drives the reset pin low for 128 reference cycles.
// RL5: Test data pin picks boot ROM in reset, later is test input or b5.
// RL6: Boot-select bit 3 of control two clears at reset when test pin low.
// RL7: Core clock reaches the shared pin only when select bit 7 is set.
// RL8: Software keeps prescaled core clock between 4 and 40 MHz.
// RL9: With PLL on, core clock runs at four times the reference.
// RL10: Resume 12 or 15 core cycles after clock restart from level 0 or 1; with oscillator power-down, CPU and clock restart together at PLL lock.
// RL11: Idle into level 1 stops core clock high after 4 core cycles.
// RL12: Oscillator powers off 4 core cycles after idle when selected.
// RL13: Any enabled interrupt or reset wakes from levels 0 and 1.
// RL14: Protect input held low 6 or 12 core cycles wakes from level 2.
// RL15: Level-2 wake relocks PLL within 4096 reference cycles, same frequency.
// RL16: Protect vector after level-2 wake only when its interrupt is enabled.
// RL17: Interrupt vector fetch no sooner than 10 core cycles after the edge.
// RL18: Protect input low puts every PWM pin in high impedance at once.
// RL19: PWM duty is 0%, 100% or whole core cycles within the period.
// RL20: All outputs come from one internal clock with aligned transitions; pwm_oe also follows the protect input directly.
// RL21: Protect wake input counts as valid only after the selected low time.
`ifndef RCL_PARAMS_SVH
`define RCL_PARAMS_SVH
// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define RCL_OFF_SC1 8'h00
`define RCL_OFF_SC2 8'h04
`define RCL_OFF_PINSEL 8'h08
`define RCL_OFF_IDLE 8'h0C
`define RCL_OFF_IRQEN 8'h10
`define RCL_OFF_STAT 8'h14
`define RCL_OFF_PWMCTL 8'h18
`define RCL_OFF_DUTY0 8'h20
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define RCL_SC1_OSCPD 5
`define RCL_SC2_BOOT 3
`define RCL_SC2_QUAL 6
`define RCL_PIN_CORE_CLOCK_OUTPUT 7
`define RCL_PWM_EN 16
// ---------------------------------------------------------------------------
// Counts in core cycles unless named reference, or half for core half-periods; RCL_PWM_N counts PWM channels
// ---------------------------------------------------------------------------
`define RCL_PWM_N 2
`define RCL_REF_DIV 4
`define RCL_LOCK_REF 4096
`define RCL_VEC_HALF 36
`define RCL_VEC_CYC ((`RCL_VEC_HALF + 1) / 2)
`define RCL_WDOG_REF 128
`define RCL_WAKE0 12
`define RCL_WAKE1 15
`define RCL_IDLE_STOP 4
`define RCL_QUAL_SHORT 6
`define RCL_QUAL_LONG 12
`define RCL_IRQ_VEC 10
`endif

/* core/rcl_pkg.sv */
// Types for the reset, clock and low-power sequencer.
// Assumes rcl_params.svh is on the include path.
`include "rcl_params.svh"
package rcl_pkg;
  typedef enum logic [3:0] {
    ST_RST, ST_LOCK, ST_VEC, ST_RUN, ST_WDOG, ST_IDLE, ST_SLEEP, ST_HALT, ST_WAKE
  } rcl_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rcl_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcl_axi_rsp_t;

  typedef struct packed {
    rcl_fsm_t st;
    logic [15:0] cnt;
    logic [1:0] refdiv;
    logic halt_wake;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] pinsel;
    logic [2:0] irq_en;
    logic general_output_port_b5;
    logic [15:0] period;
    logic pwm_en;
    logic [`RCL_PWM_N-1:0][15:0] duty;
    logic [15:0] pwm_cnt;
    logic [`RCL_PWM_N-1:0] pwm;
    logic [1:0] xi_prev;
    logic [2:0] pend;
    logic [3:0] vcnt;
    logic vbusy;
    logic [1:0] vid;
    logic vfetch;
    logic [3:0] pdp_cnt;
    logic rst_oe;
    logic osc_on;
    logic locked;
    logic cpu_run;
    logic clk_run;
    logic clk_pin;
    logic tdi_oe;
    rcl_axi_rsp_t axi;
  } rcl_state_t;
endpackage

/* tb/rcl_seq_sva.sv */
// Checker for the sequencer pins, bound to every rcl_seq instance.
// Assumes a lock count of LOCK_REF reference ticks of four core cycles each.
`timescale 1ns/10ps
`default_nettype none
`include "rcl_params.svh"
module rcl_seq_sva #(
  parameter int LOCK_REF = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched pins
  input wire logic sys_rst_pin_i,
  input wire logic sys_rst_pin_oe,
  input wire logic power_drive_protect_n,
  input wire logic [1:0] external_irq,
  input wire logic core_clock_output,
  input wire logic core_clk_run,
  input wire logic cpu_run,
  input wire logic osc_on,
  input wire logic pll_locked,
  input wire logic vec_fetch,
  input wire logic [`RCL_PWM_N-1:0] pwm_oe
);
  localparam int LOCK_MAX = 4 * LOCK_REF + 8;
  logic [9:0] oe_cnt_q;
  logic [5:0] vec_cnt_q;
  logic [5:0] run_cnt_q;
  logic rst_seen_q;
  logic osc_gone_q;
  logic clk_gone_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Counters saturate so that long sleeps cannot wrap them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_cnt_q <= 10'h0;
      vec_cnt_q <= 6'h0;
      run_cnt_q <= 6'h0;
      rst_seen_q <= 1'b1;
      osc_gone_q <= 1'b1;
      clk_gone_q <= 1'b1;
    end else begin
      oe_cnt_q <= sys_rst_pin_oe ? oe_cnt_q + {9'h0, ~&oe_cnt_q} : 10'h0;
      vec_cnt_q <= (pll_locked && !cpu_run) ? vec_cnt_q + {5'h0, ~&vec_cnt_q} : 6'h0;
      run_cnt_q <= (core_clk_run && !cpu_run) ? run_cnt_q + {5'h0, ~&run_cnt_q} : 6'h0;
      rst_seen_q <= !sys_rst_pin_i || (rst_seen_q && !cpu_run);
      osc_gone_q <= !osc_on || (osc_gone_q && !cpu_run);
      clk_gone_q <= !core_clk_run || (clk_gone_q && !cpu_run);
    end
  end
  a_pwm_tristate: assert property (!power_drive_protect_n |-> pwm_oe == '0)
    else $error("pwm enabled while protect low");
  a_clk_pin_hold: assert property (!core_clk_run [*2] |-> $stable(core_clock_output))
    else $error("clock pin moved while core clock stopped");
  a_wdog_width: assert property ($fell(sys_rst_pin_oe) |-> oe_cnt_q >= 10'h200)
    else $error("watchdog reset pulse too short");
  a_lock_bound: assert property ($rose(sys_rst_pin_i) |-> ##[1:LOCK_MAX] pll_locked)
    else $error("pll lock late after reset pin release");
  a_vec_delay: assert property ($rose(cpu_run) && rst_seen_q |-> vec_cnt_q >= 6'h12)
    else $error("reset vector too soon after lock");
  a_wake_delay: assert property (
    $rose(cpu_run) && !rst_seen_q && !osc_gone_q |-> run_cnt_q >= (clk_gone_q ? 6'hF : 6'hC))
    else $error("wake resumed too soon");
  a_irq_latency: assert property (
    $changed(external_irq) |-> !vec_fetch [*8] ##1 !vec_fetch [*2])
    else $error("vector fetch too soon after interrupt edge");
  a_fetch_run: assert property (vec_fetch |-> cpu_run)
    else $error("vector fetch while stopped");
  a_idle_stop: assert property (
    $fell(cpu_run) && sys_rst_pin_i && !sys_rst_pin_oe |-> (core_clk_run && osc_on) [*4])
    else $error("clock or oscillator stopped too soon after idle");
endmodule // rcl_seq_sva
bind rcl_seq rcl_seq_sva #(.LOCK_REF(LOCK_REF)) u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .sys_rst_pin_i(sys_rst_pin_i),
  .sys_rst_pin_oe(sys_rst_pin_oe), .power_drive_protect_n(power_drive_protect_n),
  .external_irq(external_irq), .core_clock_output(core_clock_output),
  .core_clk_run(core_clk_run), .cpu_run(cpu_run), .osc_on(osc_on), .pll_locked(pll_locked),
  .vec_fetch(vec_fetch), .pwm_oe(pwm_oe)
);
`default_nettype wire

/* tb/rcl_board_model.sv */
// Board model: reset source on a pulled-up reset pin, protect and interrupt sources.
// Assumes its tasks are entered just after a rising edge of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module rcl_board_model (
  // Clock
  input wire logic clk_sys,
  // Reset pin as driven by the sequencer
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  // Pins seen by the sequencer
  output logic rst_pin,
  output logic pdp_n,
  output logic [1:0] irq
);
  logic hold_lo;
  initial begin
    hold_lo = 1'b1;
    pdp_n = 1'b1;
    irq = 2'b00;
  end
  // Open-drain pin: low if either side pulls, otherwise the pull-up wins.
  assign rst_pin = !hold_lo && !(rst_pin_oe && !rst_pin_o);
  task automatic reset_pulse(input int n);
    hold_lo <= 1'b1;
    repeat ((n < 32) ? 32 : n) @(posedge clk_sys);
    hold_lo <= 1'b0;
  endtask
  task automatic pdp_pulse(input int n);
    pdp_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    pdp_n <= 1'b1;
  endtask
  task automatic irq_toggle(input int i);
    irq[i] <= ~irq[i];
    repeat (12) @(posedge clk_sys);
  endtask
endmodule // rcl_board_model
`default_nettype wire

/* tb/rcl_seq_test.sv */
// Self-checking bench for rcl_seq with the board model on its pins.
// Assumes rcl_pkg compiles first; the lock count is cut to 8 reference ticks.
`timescale 1ns/10ps
`default_nettype none
`include "rcl_params.svh"
module rcl_seq_test;
  import rcl_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rcl_note_t;
  logic clk_sys, rst_n, sys_rst_pin_i, sys_rst_pin_o, sys_rst_pin_oe, wdog_expire;
  logic power_drive_protect_n, tdi_i, trst_i, tdi_o, tdi_oe, core_clock_output;
  logic core_clk_run, cpu_run, osc_on, pll_locked, boot_rom_en, vec_fetch;
  logic [1:0] external_irq;
  logic [1:0] vec_id;
  logic [1:0] last_id;
  logic [`RCL_PWM_N-1:0] pwm_o;
  logic [`RCL_PWM_N-1:0] pwm_oe;
  rcl_axi_req_t axi_req;
  rcl_axi_rsp_t axi_rsp;
  rcl_note_t notes[$];
  int fails;
  int num_checks;
  int fetches = 0;
  rcl_seq #(.LOCK_REF(8)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .sys_rst_pin_i(sys_rst_pin_i), .sys_rst_pin_o(sys_rst_pin_o),
    .sys_rst_pin_oe(sys_rst_pin_oe), .wdog_expire(wdog_expire),
    .power_drive_protect_n(power_drive_protect_n), .external_irq(external_irq),
    .tdi_i(tdi_i), .trst_i(trst_i), .tdi_o(tdi_o), .tdi_oe(tdi_oe),
    .core_clock_output(core_clock_output), .core_clk_run(core_clk_run), .cpu_run(cpu_run),
    .osc_on(osc_on), .pll_locked(pll_locked), .boot_rom_en(boot_rom_en),
    .vec_fetch(vec_fetch), .vec_id(vec_id), .pwm_o(pwm_o), .pwm_oe(pwm_oe)
  );
  rcl_board_model brd (
    .clk_sys(clk_sys),
    .rst_pin_o(sys_rst_pin_o),
    .rst_pin_oe(sys_rst_pin_oe),
    .rst_pin(sys_rst_pin_i),
    .pdp_n(power_drive_protect_n),
    .irq(external_irq)
  );
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    notes.push_back('{e, r});
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (cpu_run !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("cpu_run", {31'h0, v}, {31'h0, cpu_run});
  endtask
  task automatic boot(input logic t);
    tdi_i <= t;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    brd.reset_pulse(40);
    wait_run(1'b1);
  endtask
  // Read answers are matched in order against the notes left by rd.
  always @(posedge clk_sys) begin
    if (axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1 && notes.size() > 0) begin
      chk("rresp", {30'h0, notes[0].resp}, {30'h0, axi_rsp.rresp});
      if (notes[0].resp == 2'b00) chk("rdata", notes[0].data, axi_rsp.rdata);
      void'(notes.pop_front());
    end
    if (vec_fetch === 1'b1) begin
      last_id = vec_id;
      fetches++;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
  initial begin
    int d;
    int nf;
    logic [31:0] hi;
    logic q;
    logic prev;
    void'($urandom(32'hB1B7030F));
    axi_req = '0;
    wdog_expire = 1'b0;
    trst_i = 1'b0;
    tdi_i = 1'b0;
    rst_n = 1'b0;
    fails = 0;
    num_checks = 0;
    boot(1'b0);
    chk("boot_rom", 32'h1, {31'h0, boot_rom_en});
    rd(`RCL_OFF_STAT, 32'h3D3, 2'b00);
    rd(`RCL_OFF_SC2, 32'h0, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    chk("clk_pin", 32'h0, {31'h0, core_clock_output});
    wr(`RCL_OFF_PINSEL, 32'hA0);
    prev = core_clock_output;
    @(posedge clk_sys);
    chk("clk_pin", {31'h0, ~prev}, {31'h0, core_clock_output});
    chk("b5", 32'h3, {30'h0, tdi_oe, tdi_o});
    trst_i <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("b5_oe", 32'h0, {31'h0, tdi_oe});
    trst_i <= 1'b0;
    d = $urandom_range(4, 0);
    wr(`RCL_OFF_DUTY0, d);
    wr(`RCL_OFF_DUTY0 + 8'h4, 32'h4);
    wr(`RCL_OFF_PWMCTL, 32'h1_0004);
    repeat (4) @(posedge clk_sys);
    hi = 0;
    repeat (8) begin
      @(posedge clk_sys);
      hi += pwm_o[0];
      chk("pwm_full", 32'h1, {31'h0, pwm_o[1]});
    end
    chk("pwm_duty", 32'(2 * d), hi);
    chk("pwm_oe", 32'h3, {30'h0, pwm_oe});
    fork
      brd.pdp_pulse(20);
      #1 chk("pwm_oe", 32'h0, {30'h0, pwm_oe});
    join
    rd(`RCL_OFF_PWMCTL, 32'h4, 2'b00);
    wr(`RCL_OFF_IRQEN, 32'h7);
    nf = fetches;
    brd.irq_toggle(0);
    repeat (20) @(posedge clk_sys);
    chk("vec_id", 32'h0, {30'h0, last_id});
    chk("vec_count", 32'(nf + 1), 32'(fetches));
    for (int lv = 0; lv < 2; lv++) begin
      wr(`RCL_OFF_SC1, lv);
      wr(`RCL_OFF_IDLE, 32'h1);
      repeat (10) @(posedge clk_sys);
      chk("clk_run", 32'(lv == 0), {31'h0, core_clk_run});
      if (lv == 1) chk("clk_stop", 32'h1, {31'h0, core_clock_output});
      chk("asleep", 32'h0, {31'h0, cpu_run});
      brd.irq_toggle(1);
      wait_run(1'b1);
    end
    q = 1'($urandom_range(1, 0));
    wr(`RCL_OFF_SC2, {25'h0, q, 6'h0});
    wr(`RCL_OFF_SC1, 32'h16);
    wr(`RCL_OFF_IDLE, 32'h1);
    repeat (10) @(posedge clk_sys);
    chk("osc_on", 32'h0, {31'h0, osc_on});
    brd.pdp_pulse(q ? 11 : 5);
    repeat (20) @(posedge clk_sys);
    chk("halted", 32'h0, {31'h0, cpu_run});
    nf = fetches;
    brd.pdp_pulse(q ? 12 : 6);
    wait_run(1'b1);
    repeat (20) @(posedge clk_sys);
    chk("vec_id", 32'h2, {30'h0, last_id});
    chk("vec_count", 32'(nf + 1), 32'(fetches));
    rd(`RCL_OFF_SC1, 32'h16, 2'b00);
    wdog_expire <= 1'b1;
    @(posedge clk_sys);
    wdog_expire <= 1'b0;
    wait_run(1'b0);
    wait_run(1'b1);
    boot(1'b1);
    rd(`RCL_OFF_STAT, 32'h3C3, 2'b00);
    rd(`RCL_OFF_SC2, 32'h8, 2'b00);
    stop_test();
  end
endmodule // rcl_seq_test
`default_nettype wire
